//--- verilog/dht_pkg.sv
// Package of constants for the head and control tag decoder
package dht_pkg;
  // Bus and field layout
  localparam int BUS_W = 10;
  localparam int HEAD_LO = 0;
  localparam int HEAD_W = 2;
  localparam int CHIP_LO = 2;
  localparam int CHIP_W = 2;
  // Control bit positions
  localparam int CB_WRITE = 0;
  localparam int CB_READ = 1;
  localparam int CB_OFS_POS = 2;
  localparam int CB_OFS_NEG = 3;
  localparam int CB_FCLR = 4;
  localparam int CB_AMARK = 5;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_HADDR = 8'h08;
  // Control register fields
  localparam int CTRL_UNIT_LO = 0;
  localparam int CTRL_OFS_EN = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Offset settle time
  localparam real CLK_NS = 5.0;
  localparam real OFS_HOLD_MS = 2.75;
  localparam int OFS_HOLD_CYC = int'(OFS_HOLD_MS * 1.0e6 / CLK_NS);
  localparam int OFS_CNT_W = 20;
  // On-cylinder suppression states
  typedef enum logic [0:0] {DHT_ON_CYL, DHT_OFFSETTING} dht_ofs_t;
endpackage

//--- verilog/dht_tag_decode.sv
// Head-select and control-select tag decoder of a disk drive
// Function
// - Head tag loads bus bits 0-3
// - Bits 0-1 head, 2-3 chip, rest ignored
// - Control tag drives command logic from bits
// - Each bit position is its own operation
// - Bit 0 write gate, refused on faults
// - Bit 1 read gate, refused on faults
// - Read rising edge starts zero-pattern sync
// - Bit 2 offsets inward, drops on-cylinder
// - Bit 3 offsets outward, drops on-cylinder
// - Fault clears only when cause is gone
// - Bit 5 with write records address mark
// - Bit 5 with read searches address mark
// - Bus meaning follows the active tag
// - On-cylinder drops during any positioner motion
// - Tags obeyed only when unit selected
//
// Our own choices: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
module dht_tag_decode
  import dht_pkg::*;
#(
  parameter int OFS_CYCLES = OFS_HOLD_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Control cable
  input wire logic [3:0] unit_sel,
  input wire logic head_tag,
  input wire logic ctrl_tag,
  input wire logic [BUS_W-1:0] bus,
  output logic on_cyl,
  // Drive status inputs
  input wire logic seek_err,
  input wire logic fault_cond,
  input wire logic on_track,
  // Drive function outputs
  output logic [HEAD_W-1:0] head_num,
  output logic [CHIP_W-1:0] chip_sel,
  output logic write_en,
  output logic read_en,
  output logic sync_zero,
  output logic amark_write,
  output logic amark_search,
  output logic ofs_pos,
  output logic ofs_neg,
  output logic fault
);

  // Register state
  logic [3:0] unit_num, next_unit_num;
  logic ofs_en, next_ofs_en;
  logic ap_wr, next_ap_wr, ap_rd, next_ap_rd;
  logic [7:0] ap_addr, next_ap_addr;
  logic [31:0] next_hrdata;
  // Drive state
  logic [HEAD_W-1:0] next_head_num;
  logic [CHIP_W-1:0] next_chip_sel;
  logic next_write_en, next_read_en, next_sync_zero;
  logic next_amark_write, next_amark_search;
  logic next_ofs_pos, next_ofs_neg, next_fault;
  logic next_on_cyl;
  dht_ofs_t ofs_st, next_ofs_st;
  logic [OFS_CNT_W-1:0] ofs_cnt, next_ofs_cnt;
  logic selected, head_go, ctrl_go, blocked, ofs_req;

  // Register slave is zero-wait, so hreadyout is always high
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Bus decode and register file
  always_comb begin
    logic take;
    take = hsel && hready && htrans[1];
    next_ap_wr = take && hwrite;
    next_ap_rd = take && !hwrite;
    next_ap_addr = haddr[7:0];
    next_unit_num = unit_num;
    next_ofs_en = ofs_en;
    next_hrdata = hrdata;
    if (ap_wr && ap_addr == OFF_CTRL) begin
      next_unit_num = hwdata[CTRL_UNIT_LO +: 4];
      next_ofs_en = hwdata[CTRL_OFS_EN];
    end
    // Read data is prepared in the address phase
    if (next_ap_rd) begin
      case (haddr[7:0])
        OFF_CTRL: next_hrdata = {27'h000_0000, next_ofs_en, next_unit_num};
        OFF_STAT: next_hrdata = {22'h00_0000, fault, on_cyl, ofs_neg,
                                 ofs_pos, amark_search, amark_write,
                                 sync_zero, read_en, write_en, selected};
        OFF_HADDR: next_hrdata = {28'h000_0000, chip_sel, head_num};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_num <= CTRL_RESET[CTRL_UNIT_LO +: 4];
      ofs_en <= CTRL_RESET[CTRL_OFS_EN];
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      unit_num <= next_unit_num;
      ofs_en <= next_ofs_en;
      ap_wr <= next_ap_wr;
      ap_rd <= next_ap_rd;
      ap_addr <= next_ap_addr;
      hrdata <= next_hrdata;
    end
  end

  // Tag qualification; the bus meaning depends on which tag is up
  assign selected = (unit_sel == unit_num);
  assign head_go = selected && head_tag;
  assign ctrl_go = selected && ctrl_tag && !head_tag;
  assign blocked = seek_err || fault;
  assign ofs_req = ctrl_go && ofs_en && (bus[CB_OFS_POS] || bus[CB_OFS_NEG]);

  // Command decode: each bit acts on its own, several may share a tag
  always_comb begin
    next_head_num = head_num;
    next_chip_sel = chip_sel;
    if (head_go) begin
      next_head_num = bus[HEAD_LO +: HEAD_W];
      next_chip_sel = bus[CHIP_LO +: CHIP_W];
    end
    // Gates follow the tag level; refused while a fault stands
    next_write_en = ctrl_go && bus[CB_WRITE] && !blocked;
    next_read_en = ctrl_go && bus[CB_READ] && !blocked;
    next_sync_zero = next_read_en && !read_en;
    next_amark_write = next_write_en && bus[CB_AMARK];
    next_amark_search = next_read_en && bus[CB_AMARK];
    next_ofs_pos = ctrl_go && ofs_en && bus[CB_OFS_POS];
    next_ofs_neg = ctrl_go && ofs_en && bus[CB_OFS_NEG];
    // Fault: the live cause sets and wins over a clear pulse
    next_fault = fault;
    if (fault_cond)
      next_fault = 1'b1;
    else if (ctrl_go && bus[CB_FCLR])
      next_fault = 1'b0;
  end

  // On-cylinder suppression after a servo offset command
  always_comb begin
    next_ofs_st = ofs_st;
    next_ofs_cnt = ofs_cnt;
    case (ofs_st)
      DHT_ON_CYL: begin
        if (ofs_req) begin
          next_ofs_st = DHT_OFFSETTING;
          next_ofs_cnt = OFS_CNT_W'(OFS_CYCLES - 1);
        end
      end
      DHT_OFFSETTING: begin
        if (ofs_req)
          next_ofs_cnt = OFS_CNT_W'(OFS_CYCLES - 1);
        else if (ofs_cnt == '0)
          next_ofs_st = DHT_ON_CYL;
        else
          next_ofs_cnt = ofs_cnt - 1'b1;
      end
      default: next_ofs_st = DHT_ON_CYL;
    endcase
    // Held low while offset settles or track is lost
    next_on_cyl = on_track && !ofs_req
                  && next_ofs_st == DHT_ON_CYL;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      head_num <= '0;
      chip_sel <= '0;
      write_en <= 1'b0;
      read_en <= 1'b0;
      sync_zero <= 1'b0;
      amark_write <= 1'b0;
      amark_search <= 1'b0;
      ofs_pos <= 1'b0;
      ofs_neg <= 1'b0;
      fault <= 1'b0;
      ofs_st <= DHT_ON_CYL;
      ofs_cnt <= '0;
      on_cyl <= 1'b0;
    end else if (clk_en) begin
      head_num <= next_head_num;
      chip_sel <= next_chip_sel;
      write_en <= next_write_en;
      read_en <= next_read_en;
      sync_zero <= next_sync_zero;
      amark_write <= next_amark_write;
      amark_search <= next_amark_search;
      ofs_pos <= next_ofs_pos;
      ofs_neg <= next_ofs_neg;
      fault <= next_fault;
      ofs_st <= next_ofs_st;
      ofs_cnt <= next_ofs_cnt;
      on_cyl <= next_on_cyl;
    end
  end

  // Multi-step behaviours
  sequence s_read_rise;
    !read_en ##1 read_en;
  endsequence

  a_head_load: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && head_go |=> head_num == $past(bus[1:0])
      && chip_sel == $past(bus[3:2]))
    else $error("head address not loaded");
  a_head_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !head_go |=> $stable(head_num) && $stable(chip_sel))
    else $error("head address changed without tag");
  a_write_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && blocked |=> !write_en)
    else $error("write accepted under fault");
  a_read_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && blocked |=> !read_en)
    else $error("read accepted under fault");
  a_read_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_rise |-> sync_zero ##1 (!sync_zero || !clk_en))
    else $error("zero sync missing on read rise");
  a_mark_write: assert property (@(posedge hclk) disable iff (!hresetn)
    amark_write |-> write_en && !amark_search)
    else $error("address mark write without write gate");
  a_mark_search: assert property (@(posedge hclk) disable iff (!hresetn)
    amark_search |-> read_en)
    else $error("address mark search without read gate");
  a_fault_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && fault_cond |=> fault)
    else $error("fault cleared while cause present");
  a_ofs_oncyl: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ofs_req |=> !on_cyl [*2])
    else $error("on-cylinder shown during offset");
  a_unsel_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !selected |=> !write_en && !read_en)
    else $error("command obeyed while unselected");

  // Accepted gate commands: selected, tagged, bit set, no fault
  sequence s_write_cmd;
    clk_en && ctrl_go && bus[CB_WRITE] && !blocked;
  endsequence
  sequence s_read_cmd;
    clk_en && ctrl_go && bus[CB_READ] && !blocked;
  endsequence

  // Each control bit must take effect on its own
  a_write_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    s_write_cmd |=> write_en)
    else $error("write gate not raised");
  a_read_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_cmd |=> read_en)
    else $error("read gate not raised");
  a_mark_record: assert property (@(posedge hclk) disable iff (!hresetn)
    s_write_cmd ##0 bus[CB_AMARK] |=> amark_write)
    else $error("address mark not recorded");
  a_mark_seek: assert property (@(posedge hclk) disable iff (!hresetn)
    s_read_cmd ##0 bus[CB_AMARK] |=> amark_search)
    else $error("address mark search not started");
  a_sync_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    sync_zero |-> read_en)
    else $error("zero sync without read gate");
  a_ofs_pos_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ctrl_go && ofs_en && bus[CB_OFS_POS] |=> ofs_pos)
    else $error("inward offset not raised");
  a_ofs_neg_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ctrl_go && ofs_en && bus[CB_OFS_NEG] |=> ofs_neg)
    else $error("outward offset not raised");
  a_ofs_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !ofs_en |=> !ofs_pos && !ofs_neg)
    else $error("offset taken while disabled");
  a_fault_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ctrl_go && bus[CB_FCLR] && !fault_cond |=> !fault)
    else $error("fault not cleared after cause gone");

  // On-cylinder only follows a held track
  a_oncyl_track: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !on_track |=> !on_cyl)
    else $error("on-cylinder shown off track");
  a_oncyl_rise: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(on_cyl) |-> $past(on_track))
    else $error("on-cylinder rose without track");

  // Tag qualification: bus meaning follows the tag and the unit match
  a_unsel_head: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !selected |=> $stable(head_num) && $stable(chip_sel))
    else $error("head address loaded while unselected");
  a_tag_priority: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && head_tag && ctrl_tag |=> !write_en && !read_en)
    else $error("control bits obeyed under head tag");
  a_ctrl_head_free: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && ctrl_go |=> $stable(head_num) && $stable(chip_sel))
    else $error("head address changed by control tag");

endmodule // dht_tag_decode

//--- dv/dht_ctrl_model.sv
// Controller-side model driving the tag and bus lines
`timescale 1ns/10ps
module dht_ctrl_model
  import dht_pkg::*;
(
  // Cable
  input wire logic hclk,
  output logic head_tag,
  output logic ctrl_tag,
  output logic [BUS_W-1:0] bus
);
  // Idle cable
  initial begin
    head_tag = 1'b0;
    ctrl_tag = 1'b0;
    bus = 10'h000;
  end
  // One-cycle strobe; released bus shows the inverse so no stale value
  task automatic strobe(input logic hd, input logic [BUS_W-1:0] v);
    @(posedge hclk);
    head_tag <= hd;
    ctrl_tag <= ~hd;
    bus <= v;
    @(posedge hclk);
    head_tag <= 1'b0;
    ctrl_tag <= 1'b0;
    bus <= ~v;
  endtask
endmodule // dht_ctrl_model

//--- dv/disk_head_and_control_tag_decode_tb.sv
// Testbench for the head and control tag decoder
`timescale 1ns/10ps
module disk_head_and_control_tag_decode_tb;
  import dht_pkg::*;
  logic hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, head_num, chip_sel;
  logic [2:0] hsize;
  logic [3:0] unit_sel;
  logic head_tag, ctrl_tag, seek_err, fault_cond, on_track, on_cyl;
  logic [BUS_W-1:0] bus;
  logic write_en, read_en, sync_zero, amark_write, amark_search;
  logic ofs_pos, ofs_neg, fault;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // Short offset hold keeps the run brief
  dht_tag_decode #(.OFS_CYCLES(20)) i_dut (.hclk, .hresetn, .clk_en,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .unit_sel, .head_tag, .ctrl_tag, .bus,
    .on_cyl, .seek_err, .fault_cond, .on_track, .head_num, .chip_sel,
    .write_en, .read_en, .sync_zero, .amark_write, .amark_search,
    .ofs_pos, .ofs_neg, .fault);
  dht_ctrl_model i_ctl (.hclk, .head_tag, .ctrl_tag, .bus);
  // Clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single word transfer; waits on hready, never on a cycle count
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input logic hd, input logic [BUS_W-1:0] v);
    i_ctl.strobe(hd, v);
    #1;
  endtask
  task automatic t_regs;
    ahb(1'b1, OFF_CTRL, 32'h0000_0013);
    ahb(1'b0, OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0013);
    ahb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_head;
    cmd(1'b1, 10'h3F6);
    chk({chip_sel, head_num}, 32'h0000_0006);
    ahb(1'b0, OFF_HADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    cmd(1'b0, 10'h003);
    chk({chip_sel, head_num}, 32'h0000_0006);
    chk({write_en, read_en}, 32'h0000_0003);
  endtask
  task automatic t_rw;
    cmd(1'b0, 10'h022);
    chk({sync_zero, read_en, amark_search, write_en}, 32'h0000_000E);
    @(posedge hclk);
    #1;
    chk(sync_zero, 32'h0000_0000);
    cmd(1'b0, 10'h021);
    chk({write_en, amark_write, read_en}, 32'h0000_0006);
  endtask
  task automatic t_refuse;
    @(posedge hclk);
    seek_err <= 1'b1;
    cmd(1'b0, 10'h003);
    chk({write_en, read_en}, 32'h0000_0000);
    @(posedge hclk);
    seek_err <= 1'b0;
    unit_sel <= 4'h5;
    cmd(1'b0, 10'h001);
    chk(write_en, 32'h0000_0000);
    @(posedge hclk);
    unit_sel <= 4'h3;
  endtask
  task automatic t_fault;
    @(posedge hclk);
    fault_cond <= 1'b1;
    cmd(1'b0, 10'h011);
    chk({fault, write_en}, 32'h0000_0002);
    @(posedge hclk);
    fault_cond <= 1'b0;
    cmd(1'b0, 10'h010);
    chk(fault, 32'h0000_0000);
  endtask
  task automatic t_ofs;
    cmd(1'b0, 10'h004);
    chk({ofs_pos, ofs_neg, on_cyl}, 32'h0000_0004);
    repeat (15) @(posedge hclk);
    #1;
    chk(on_cyl, 32'h0000_0000);
    repeat (10) @(posedge hclk);
    #1;
    chk(on_cyl, 32'h0000_0001);
    cmd(1'b0, 10'h008);
    chk({ofs_pos, ofs_neg, on_cyl}, 32'h0000_0002);
    @(posedge hclk);
    on_track <= 1'b0;
    repeat (30) @(posedge hclk);
    #1;
    chk(on_cyl, 32'h0000_0000);
    ahb(1'b0, OFF_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    chk(hresp, 32'h0000_0000);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, well above the hundred or so cycles the run needs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, seek_err, fault_cond} = 5'b0_0000;
    {clk_en, on_track} = 2'b11;
    {haddr, hwdata, htrans} = 66'h0;
    hsize = 3'b010;
    unit_sel = 4'h3;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_head;
    t_rw;
    t_refuse;
    t_fault;
    t_ofs;
    end_of_test;
  end
endmodule // disk_head_and_control_tag_decode_tb
